/* File: rtl/midt_core.sv */
// Overview of operation
// - ordinary instruction is one 16-bit word: opcode plus operand fields
// - four instructions span two words; second word fetched before completion
// - second word has top four bits set; alone it executes as no-op
// - single word takes one cycle; taken test or jump adds no-op cycle
// - two-word instructions take two instruction cycles
// - one instruction cycle is four oscillator periods
// - taken two-word branch costs two cycles; skip over two words costs three
// - destination bit zero writes accumulator, one writes file register
// - byte operations carry file address, destination bit, access bit
// - bit operations carry file address, bit number, access bit
// - literal operations carry constant, pointer selector, or nothing
// - control operations carry address, fast mode, table mode, or nothing
// - access bit zero uses access RAM, one uses bank selector
// - fast bit one saves or restores shadows; zero leaves them alone
// - three-bit bit number picks bit 0 to 7 of byte
`timescale 1ns/1ps
`default_nettype none
module midt_core (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [midt_pkg::WORD_WIDTH-1:0] fetchWord,
   input wire logic condTrue,
   input wire logic [midt_pkg::PC_WIDTH-1:0] returnAddr,
   output logic [midt_pkg::PC_WIDTH-1:0] progAddr_r,
   output logic [1:0] qPhase_r,
   output logic cycleStart_r,
   output logic [midt_pkg::WORD_WIDTH-1:0] instrWord_r,
   output logic [midt_pkg::WORD_WIDTH-1:0] instrHold_r,
   output midt_pkg::midt_class_t instrClass_r,
   output logic secondWord_r,
   output logic nopCycle_r,
   output logic [7:0] fileAddr_r,
   output logic destToFile_r,
   output logic useBankSel_r,
   output logic [2:0] bitNumber_r,
   output logic [7:0] bitMask_r,
   output logic [11:0] literal_r,
   output logic [1:0] pointerSel_r,
   output logic fastMode_r,
   output logic tableMode_r,
   output logic [1:0] tableOp_r
);
   import midt_pkg::*;

   midt_state_t state_r;
   midt_state_t state_nxt;
   logic [PC_WIDTH-1:0] pc_nxt;
   logic [WORD_WIDTH-1:0] ir_nxt;
   logic [WORD_WIDTH-1:0] hold_nxt;
   logic endCycle;
   logic [WORD_WIDTH-1:0] decWord;

   function automatic logic isTwoWord(input logic [15:0] w);
      return (w[15:12] == OPC_MOVE_FF) || (w[15:10] == OPC_LONG_GRP);
   endfunction : isTwoWord

   function automatic logic isLongJump(input logic [15:0] w);
      return (w[15:10] == OPC_LONG_GRP) && (w[9:8] != OPC_LONG_LFSR);
   endfunction : isLongJump

   function automatic logic isJump(input logic [15:0] w);
      return (w[15:12] == OPC_REL_BRANCH) || (w[15:2] == OPC_RETURN_GRP)
         || (w[15:8] == OPC_RET_LIT);
   endfunction : isJump

   function automatic logic isReturn(input logic [15:0] w);
      return (w[15:2] == OPC_RETURN_GRP) || (w[15:8] == OPC_RET_LIT);
   endfunction : isReturn

   function automatic logic isSkip(input logic [15:0] w);
      return (w[15:13] == OPC_BIT_TEST) || (w[15:10] == OPC_DEC_SKIP)
         || (w[15:10] == OPC_INC_SKIP) || (w[15:10] == OPC_INC_SKNZ)
         || (w[15:10] == OPC_DEC_SKNZ) || (w[15:11] == OPC_CMP_SKIP);
   endfunction : isSkip

   function automatic logic isTable(input logic [15:0] w);
      return (w[15:4] == OPC_MISC_GRP) && w[3];
   endfunction : isTable

   function automatic midt_class_t classify(input logic [15:0] w);
      midt_class_t c;
      c = CLS_BYTE;
      if (w[15:12] == SECOND_WORD_TAG) begin
         c = CLS_NOP;
      end else if (w == NOP_WORD) begin
         c = CLS_NOP;
      end else if (w[15:12] >= OPC_BIT_LO && w[15:12] <= OPC_BIT_HI) begin
         c = CLS_BIT;
      end else if (w[15:11] == OPC_LIT_GRP || w[15:8] == OPC_MOVE_BANK
            || (w[15:10] == OPC_LONG_GRP && w[9:8] == OPC_LONG_LFSR)) begin
         c = CLS_LIT;
      end else if (w[15:12] == OPC_REL_BRANCH || w[15:12] == OPC_CTRL_E
            || w[15:8] == 8'h00) begin
         c = CLS_CTRL;
      end
      return c;
   endfunction : classify

   function automatic logic [PC_WIDTH-1:0] sext8(input logic [7:0] v);
      return {{(PC_WIDTH-8){v[7]}}, v};
   endfunction : sext8

   function automatic logic [PC_WIDTH-1:0] sext11(input logic [10:0] v);
      return {{(PC_WIDTH-11){v[10]}}, v};
   endfunction : sext11

   assign endCycle = (qPhase_r == Q_LAST);

   // four clocks per instruction cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         qPhase_r <= Q_FIRST;
         cycleStart_r <= 1'b0;
      end else begin
         qPhase_r <= qPhase_r + 2'h1;
         cycleStart_r <= endCycle;
      end
   end

   // sequencing of the word in execution against the word being fetched
   always_comb begin
      state_nxt = ST_EXEC;
      pc_nxt = progAddr_r + 20'h00001;
      ir_nxt = fetchWord;
      hold_nxt = instrHold_r;
      case (state_r)
         ST_EXEC: begin
            if (isTwoWord(instrWord_r)) begin
               // fetched word completes the 32-bit encoding
               state_nxt = ST_SECOND;
               hold_nxt = instrWord_r;
               if (isLongJump(instrWord_r) && instrWord_r[9:8] != 2'b00
                     || instrWord_r[15:8] == 8'hef) begin
                  pc_nxt = {fetchWord[11:0], instrWord_r[7:0]};
               end
            end else if (isJump(instrWord_r)
                  || (instrWord_r[15:11] == OPC_COND_BRANCH && condTrue)) begin
               state_nxt = ST_FLUSH;
               ir_nxt = NOP_WORD;
               if (isReturn(instrWord_r)) begin
                  pc_nxt = returnAddr;
               end else if (instrWord_r[15:12] == OPC_REL_BRANCH) begin
                  pc_nxt = progAddr_r + sext11(instrWord_r[10:0]);
               end else begin
                  pc_nxt = progAddr_r + sext8(instrWord_r[7:0]);
               end
            end else if (isSkip(instrWord_r) && condTrue) begin
               // a skipped two-word instruction leaves its tagged second
               // word to run as a further no-op, giving three cycles
               state_nxt = ST_FLUSH;
               ir_nxt = NOP_WORD;
            end
         end
         ST_SECOND: begin
            state_nxt = ST_EXEC;
         end
         ST_FLUSH: begin
            state_nxt = ST_EXEC;
         end
         default: begin
            state_nxt = ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_FLUSH;
         progAddr_r <= PC_RESET;
         instrWord_r <= NOP_WORD;
         instrHold_r <= NOP_WORD;
      end else if (endCycle) begin
         state_r <= state_nxt;
         progAddr_r <= pc_nxt;
         instrWord_r <= ir_nxt;
         instrHold_r <= hold_nxt;
      end
   end

   // fields describe the whole instruction, first word while in second half
   assign decWord = (state_nxt == ST_SECOND) ? hold_nxt : ir_nxt;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         instrClass_r <= CLS_NOP;
         secondWord_r <= 1'b0;
         nopCycle_r <= 1'b1;
      end else if (endCycle) begin
         secondWord_r <= (state_nxt == ST_SECOND);
         nopCycle_r <= (state_nxt == ST_FLUSH);
         instrClass_r <= classify(decWord);
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fileAddr_r <= 8'h00;
         destToFile_r <= 1'b0;
         useBankSel_r <= 1'b0;
         bitNumber_r <= 3'h0;
         bitMask_r <= 8'h00;
      end else if (endCycle) begin
         fileAddr_r <= decWord[FILE_MSB:FILE_LSB];
         destToFile_r <= (classify(decWord) == CLS_BYTE)
            && decWord[DEST_BIT];
         useBankSel_r <= (classify(decWord) == CLS_BYTE
            || classify(decWord) == CLS_BIT) && decWord[ACCESS_BIT];
         bitNumber_r <= decWord[BITNUM_MSB:BITNUM_LSB];
         bitMask_r <= (classify(decWord) == CLS_BIT)
            ? (8'h01 << decWord[BITNUM_MSB:BITNUM_LSB]) : 8'h00;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         literal_r <= 12'h000;
         pointerSel_r <= 2'h0;
         fastMode_r <= 1'b0;
         tableMode_r <= 1'b0;
         tableOp_r <= 2'h0;
      end else if (endCycle) begin
         // pointer load literal is split over the two words
         if (state_nxt == ST_SECOND && hold_nxt[15:8] == 8'hee) begin
            literal_r <= {hold_nxt[3:0], ir_nxt[7:0]};
         end else begin
            literal_r <= {4'h0, decWord[7:0]};
         end
         pointerSel_r <= decWord[PTR_MSB:PTR_LSB];
         // shadows are only touched when the fast bit is set
         if (isReturn(decWord) && decWord[15:8] != OPC_RET_LIT) begin
            fastMode_r <= decWord[RET_FAST_BIT];
         end else if (decWord[15:9] == 7'b1110110) begin
            fastMode_r <= decWord[CALL_FAST_BIT];
         end else begin
            fastMode_r <= 1'b0;
         end
         tableMode_r <= isTable(decWord);
         tableOp_r <= decWord[1:0];
      end
   end

endmodule : midt_core
`default_nettype wire

/* File: pkg/midt_pkg.sv */
package midt_pkg;

   // instruction cycle built from oscillator periods (one clock each)
   localparam int unsigned Q_PER_CYCLE = 4;
   localparam int unsigned Q_WIDTH = 2;
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam logic [1:0] Q_FIRST = 2'h0;

   localparam int unsigned WORD_WIDTH = 16;
   localparam int unsigned PC_WIDTH = 20;
   localparam logic [19:0] PC_RESET = 20'h00000;
   localparam logic [15:0] NOP_WORD = 16'h0000;

   // second word of a two-word instruction carries this in its top nibble
   localparam logic [3:0] SECOND_WORD_TAG = 4'hf;

   // operand field positions
   localparam int unsigned FILE_LSB = 0;
   localparam int unsigned FILE_MSB = 7;
   localparam int unsigned ACCESS_BIT = 8;
   localparam int unsigned DEST_BIT = 9;
   localparam int unsigned BITNUM_LSB = 9;
   localparam int unsigned BITNUM_MSB = 11;
   localparam int unsigned CALL_FAST_BIT = 8;
   localparam int unsigned RET_FAST_BIT = 0;
   localparam int unsigned PTR_LSB = 4;
   localparam int unsigned PTR_MSB = 5;

   // opcode patterns
   localparam logic [3:0] OPC_MOVE_FF = 4'hc;
   localparam logic [5:0] OPC_LONG_GRP = 6'b111011;
   localparam logic [1:0] OPC_LONG_LFSR = 2'b10;
   localparam logic [3:0] OPC_REL_BRANCH = 4'hd;
   localparam logic [4:0] OPC_COND_BRANCH = 5'b11100;
   localparam logic [13:0] OPC_RETURN_GRP = 14'h0004;
   localparam logic [7:0] OPC_RET_LIT = 8'h0c;
   localparam logic [11:0] OPC_MISC_GRP = 12'h000;
   localparam logic [2:0] OPC_BIT_TEST = 3'b101;
   localparam logic [5:0] OPC_DEC_SKIP = 6'b001011;
   localparam logic [5:0] OPC_INC_SKIP = 6'b001111;
   localparam logic [5:0] OPC_INC_SKNZ = 6'b010010;
   localparam logic [5:0] OPC_DEC_SKNZ = 6'b010011;
   localparam logic [4:0] OPC_CMP_SKIP = 5'b01100;
   localparam logic [3:0] OPC_BIT_LO = 4'h7;
   localparam logic [3:0] OPC_BIT_HI = 4'hb;
   localparam logic [4:0] OPC_LIT_GRP = 5'b00001;
   localparam logic [7:0] OPC_MOVE_BANK = 8'h01;
   localparam logic [3:0] OPC_CTRL_E = 4'he;

   typedef enum logic [2:0] {
      CLS_NOP = 3'b000,
      CLS_BYTE = 3'b001,
      CLS_BIT = 3'b010,
      CLS_LIT = 3'b011,
      CLS_CTRL = 3'b100
   } midt_class_t;

   typedef enum logic [1:0] {
      ST_EXEC = 2'b00,
      ST_SECOND = 2'b01,
      ST_FLUSH = 2'b10
   } midt_state_t;

endpackage : midt_pkg

/* File: verif/midt_core_props.sv */
`timescale 1ns/1ps
`default_nettype none
module midt_core_props (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [1:0] qPhase_r,
   input wire logic cycleStart_r,
   input wire logic [19:0] progAddr_r,
   input wire logic [15:0] instrWord_r,
   input wire midt_pkg::midt_class_t instrClass_r,
   input wire logic secondWord_r,
   input wire logic nopCycle_r,
   input wire logic [7:0] fileAddr_r,
   input wire logic destToFile_r,
   input wire logic useBankSel_r,
   input wire logic [2:0] bitNumber_r,
   input wire logic [7:0] bitMask_r,
   input wire logic [11:0] literal_r,
   input wire logic [15:0] instrHold_r,
   input wire logic [1:0] pointerSel_r,
   input wire logic fastMode_r,
   input wire logic tableMode_r,
   input wire logic [1:0] tableOp_r
);
   import midt_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   property p_phase;
      1'b1 |=> qPhase_r == $past(qPhase_r) + 2'h1;
   endproperty
   a_phase: assert property (p_phase) else $error("phase skipped");
   property p_start;
      qPhase_r == 2'h3 |=> cycleStart_r ##1 !cycleStart_r [*3];
   endproperty
   a_start: assert property (p_start) else $error("bad start");
   property p_hold;
      qPhase_r != 2'h0 |-> $stable(instrWord_r) && $stable(progAddr_r);
   endproperty
   a_hold: assert property (p_hold) else $error("moved mid cycle");
   property p_second;
      secondWord_r |-> instrWord_r[15:12] == SECOND_WORD_TAG;
   endproperty
   a_second: assert property (p_second) else $error("bad 2nd");
   property p_flush;
      nopCycle_r |-> instrWord_r == NOP_WORD;
   endproperty
   a_flush: assert property (p_flush) else $error("flush word");
   property p_byte;
      instrClass_r == CLS_BYTE && !secondWord_r |->
         fileAddr_r == instrWord_r[7:0]
         && destToFile_r == instrWord_r[9] && useBankSel_r == instrWord_r[8];
   endproperty
   a_byte: assert property (p_byte) else $error("byte");
   property p_bit;
      instrClass_r == CLS_BIT |-> bitNumber_r == instrWord_r[11:9]
         && bitMask_r == (8'h1 << instrWord_r[11:9]);
   endproperty
   a_bit: assert property (p_bit) else $error("bit");
   property p_lit;
      cycleStart_r && instrWord_r[15:8] == 8'h0e |->
         instrClass_r == CLS_LIT && literal_r == {4'h0, instrWord_r[7:0]};
   endproperty
   a_lit: assert property (p_lit) else $error("literal");
   property p_seq;
      cycleStart_r && instrClass_r == CLS_BYTE && !secondWord_r |->
         ##4 progAddr_r == $past(progAddr_r, 4) + 20'h1;
   endproperty
   a_seq: assert property (p_seq) else $error("not one cycle");
   property p_long;
      cycleStart_r && instrWord_r[15:8] == 8'hef && !nopCycle_r |->
         ##4 secondWord_r && !nopCycle_r ##4 !secondWord_r && !nopCycle_r;
   endproperty
   a_long: assert property (p_long) else $error("two-word");
   // a relative branch costs one discarded cycle, then the target runs
   property p_jump;
      cycleStart_r && instrWord_r[15:12] == OPC_REL_BRANCH |->
         ##4 nopCycle_r && instrWord_r == NOP_WORD ##4 !nopCycle_r;
   endproperty
   a_jump: assert property (p_jump) else $error("no flush");
   property p_table;
      cycleStart_r && instrClass_r == CLS_CTRL && instrWord_r[15:4] == 12'h000
         |-> tableMode_r == instrWord_r[3] && tableOp_r == instrWord_r[1:0];
   endproperty
   a_table: assert property (p_table) else $error("table");
   property p_fast;
      cycleStart_r && !secondWord_r && instrWord_r[15:9] == 7'b1110110 |->
         fastMode_r == instrWord_r[8];
   endproperty
   a_fast: assert property (p_fast) else $error("fast call");
   property p_nofast;
      cycleStart_r && instrClass_r != CLS_CTRL |-> !fastMode_r;
   endproperty
   a_nofast: assert property (p_nofast) else $error("fast set");
   // pointer load: literal is assembled from both words of the pair
   property p_ptr;
      cycleStart_r && secondWord_r && instrHold_r[15:8] == 8'hee |->
         literal_r == {instrHold_r[3:0], instrWord_r[7:0]}
         && pointerSel_r == instrHold_r[5:4];
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer");
   // a taken skip over a pair leaves the tagged word to run as a no-op
   property p_skip2;
      cycleStart_r && instrWord_r[15:13] == OPC_BIT_TEST && !nopCycle_r
         ##4 nopCycle_r |-> ##4 !nopCycle_r && !secondWord_r
         && (instrClass_r == CLS_NOP
         || instrWord_r[15:12] != SECOND_WORD_TAG);
   endproperty
   a_skip2: assert property (p_skip2) else $error("skip");
endmodule : midt_core_props
bind midt_core midt_core_props u_props (.clock, .reset_n, .qPhase_r,
   .cycleStart_r, .progAddr_r, .instrWord_r, .instrClass_r, .secondWord_r,
   .nopCycle_r, .fileAddr_r, .destToFile_r, .useBankSel_r, .bitNumber_r,
   .bitMask_r, .literal_r, .instrHold_r, .pointerSel_r, .fastMode_r,
   .tableMode_r, .tableOp_r);
`default_nettype wire

/* File: verif/midt_progmem.sv */
`timescale 1ns/1ps
`default_nettype none
module midt_progmem (
   input wire logic clock,
   input wire logic [midt_pkg::PC_WIDTH-1:0] progAddr,
   output logic [midt_pkg::WORD_WIDTH-1:0] fetchWord,
   output logic condTrue,
   output logic [midt_pkg::PC_WIDTH-1:0] returnAddr
);
   import midt_pkg::*;
   logic [15:0] mem [0:127];
   // lets the bench make every test true for the tail of the program
   logic forceTaken = 1'b0;
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = NOP_WORD;
      fetchWord = NOP_WORD;
      condTrue = 1'b0;
      returnAddr = 20'h0;
   end
   // one word per address, unwritten words read as no-op, addresses wrap every 128 words
   always @(posedge clock) begin
      #1;
      fetchWord <= mem[progAddr[6:0]];
      condTrue <= 1'($urandom) | forceTaken;
      returnAddr <= 20'($urandom);
   end
endmodule : midt_progmem
`default_nettype wire

/* File: verif/tb_midt_core.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_midt_core;
   import midt_pkg::*;
   logic clock, reset_n, condTrue, cycleStart_r, secondWord_r, nopCycle_r;
   logic destToFile_r, useBankSel_r, fastMode_r, tableMode_r;
   logic [15:0] fetchWord, instrWord_r, instrHold_r;
   logic [19:0] returnAddr, progAddr_r;
   logic [1:0] qPhase_r, pointerSel_r, tableOp_r;
   logic [7:0] fileAddr_r, bitMask_r;
   logic [2:0] bitNumber_r;
   logic [11:0] literal_r;
   midt_class_t instrClass_r;
   logic [65:0] notes[$];
   logic [65:0] n;
   logic [31:0] r;
   int errors = 0;
   int comparisons = 0;
   midt_core DUT (.clock, .reset_n, .fetchWord, .condTrue, .returnAddr,
      .progAddr_r, .qPhase_r, .cycleStart_r, .instrWord_r, .instrHold_r,
      .instrClass_r, .secondWord_r, .nopCycle_r, .fileAddr_r, .destToFile_r,
      .useBankSel_r, .bitNumber_r, .bitMask_r, .literal_r, .pointerSel_r,
      .fastMode_r, .tableMode_r, .tableOp_r);
   midt_progmem PM (.clock, .progAddr(progAddr_r), .fetchWord, .condTrue,
      .returnAddr);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   function automatic logic [32:0] mk(logic [2:0] c, logic [7:0] f,
         logic d, logic a, logic [7:0] m, logic [11:0] l);
      return {c, f, d, a, m, l};
   endfunction : mk
   task automatic check(logic [32:0] exp, logic [32:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : check
   task automatic results;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   // masked expectation: only the fields that the class defines
   task automatic put(int pc, logic [15:0] w, logic [32:0] e, logic [32:0] m);
      PM.mem[pc] = w;
      notes.push_back({e, m});
   endtask : put
   always @(negedge clock) begin
      if (reset_n && cycleStart_r && !nopCycle_r && !secondWord_r
            && instrClass_r !== CLS_NOP) begin
         if (notes.size() == 0) check(33'h0, {17'h0, instrWord_r});
         else begin
            n = notes.pop_front();
            check(n[65:33], n[32:0] & mk(instrClass_r, fileAddr_r,
               destToFile_r, useBankSel_r, bitMask_r, literal_r));
         end
      end
   end
   initial begin
      reset_n = 1'b0;
      void'($urandom(32'hba06d8f7));
      @(posedge clock);
      for (int i = 0; i < 20; i++) begin
         r = $urandom;
         case (i % 3)
            0: put(i, {6'b001001, r[9:0]}, mk(CLS_BYTE, r[7:0], r[9], r[8],
               8'h0, 12'h0), mk(3'h7, 8'hff, 1'b1, 1'b1, 8'h0, 12'h0));
            1: put(i, {4'h8, r[11:0]}, mk(CLS_BIT, r[7:0], 1'b0, r[8],
               8'h1 << r[11:9], 12'h0), mk(3'h7, 8'hff, 1'b0, 1'b1, 8'hff,
               12'h0));
            default: put(i, {8'h0e, r[7:0]}, mk(CLS_LIT, 8'h0, 1'b0, 1'b0,
               8'h0, {4'h0, r[7:0]}), mk(3'h7, 8'h0, 1'b0, 1'b0, 8'h0,
               12'hfff));
         endcase
      end
      // jump over the gap proves the second word was fetched
      put(20, 16'hef40, mk(CLS_CTRL, 8'h40, 1'b0, 1'b0, 8'h0, 12'h0),
         mk(3'h7, 8'hff, 1'b0, 1'b0, 8'h0, 12'h0));
      PM.mem[21] = 16'hf000;
      put(64, 16'h275a, mk(CLS_BYTE, 8'h5a, 1'b1, 1'b1, 8'h0, 12'h0),
         mk(3'h7, 8'hff, 1'b1, 1'b1, 8'h0, 12'h0));
      // words at 66 and 69 must never run: a taken jump skips them
      put(65, 16'hd001, mk(CLS_CTRL, 8'h01, 1'b0, 1'b0, 8'h0, 12'h0),
         mk(3'h7, 8'hff, 1'b0, 1'b0, 8'h0, 12'h0));
      PM.mem[66] = 16'h0e55;
      put(67, 16'hed46, mk(CLS_CTRL, 8'h46, 1'b0, 1'b0, 8'h0, 12'h0),
         mk(3'h7, 8'hff, 1'b0, 1'b0, 8'h0, 12'h0));
      PM.mem[68] = 16'hf000;
      PM.mem[69] = 16'h0e66;
      put(70, 16'h0009, mk(CLS_CTRL, 8'h09, 1'b0, 1'b0, 8'h0, 12'h0),
         mk(3'h7, 8'hff, 1'b0, 1'b0, 8'h0, 12'h0));
      put(71, 16'hee25, mk(CLS_LIT, 8'h25, 1'b0, 1'b0, 8'h0, 12'h0),
         mk(3'h7, 8'hff, 1'b0, 1'b0, 8'h0, 12'h0));
      PM.mem[72] = 16'hf0ab;
      put(73, 16'ha000, mk(CLS_BIT, 8'h00, 1'b0, 1'b0, 8'h01, 12'h0),
         mk(3'h7, 8'hff, 1'b0, 1'b1, 8'hff, 12'h0));
      PM.mem[74] = 16'hc000;
      PM.mem[75] = 16'hf000;
      repeat (3) @(posedge clock);
      #1 reset_n = 1'b1;
      for (int t = 0; t < 600 && notes.size() > 1; t++) @(posedge clock);
      // only the final skip is left: make it taken over the pair
      PM.forceTaken = 1'b1;
      for (int t = 0; t < 100 && notes.size() > 0; t++) @(posedge clock);
      if (notes.size() > 0) check(33'h0, 33'(notes.size()));
      repeat (16) @(posedge clock);
      results();
   end
endmodule : tb_midt_core
`default_nettype wire
